// ---- pin_gpio_pkg.sv ----
// Package: register map, field positions and bus carriers of the pin data path.
// Assumes an AXI4-Lite master with 32-bit data and one aligned word per register.
package pin_gpio_pkg;

  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 32;
  localparam int          SYNC_STAGES     = 2;

  // Byte offsets
  localparam logic [5:0]  OFS_INPUT_LEVEL = 6'h00;
  localparam logic [5:0]  OFS_OUT_VALUE   = 6'h04;
  localparam logic [5:0]  OFS_OUT_SET     = 6'h08;
  localparam logic [5:0]  OFS_OUT_CLEAR   = 6'h0C;
  localparam logic [5:0]  OFS_ROLE        = 6'h10;
  localparam logic [5:0]  OFS_DIRECTION   = 6'h14;

  // Field positions
  localparam int          BIT_CLOCK_PIN   = 0;
  localparam int          BIT_DATA_PIN    = 1;
  localparam int          BIT_ROLE        = 0;

  localparam logic [1:0]  OUT_VALUE_RST   = 2'h0;
  localparam logic [1:0]  DIRECTION_RST   = 2'h0;
  localparam logic        ROLE_RST        = 1'h0;
  localparam logic        ROLE_GPIO       = 1'h1;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    data;
    logic [3:0]           strb;
  } wr_req_s;

  typedef struct packed {
    logic [DATA_W-1:0]    data;
    logic [1:0]           resp;
  } rd_rsp_s;

  // Drive pair of one two-wire pin
  typedef struct packed {
    logic                 out;
    logic                 oe;
  } pin_drive_s;

endpackage : pin_gpio_pkg

// ---- pin_level_sync.sv ----
// Two-stage synchroniser for the pin input levels.
// Assumes pin levels may change at any time relative to aclk.
`timescale 1ns/10ps
module pin_level_sync #(
  parameter int WIDTH  = 2,
  parameter int STAGES = 2
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import pin_gpio_pkg::*;

  logic [STAGES-1:0][WIDTH-1:0] stage;
  logic [STAGES-1:0][WIDTH-1:0] next_stage;

  initial begin
    if (STAGES < 2 || WIDTH < 1) begin
      $error("pin_level_sync: STAGES must be at least 2");
    end
  end

  // First stage feeds only the next flop
  always_comb begin
    next_stage = {stage[STAGES-2:0], async_in};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Idle bus level; a low here would look like a start to the engine
      stage <= '1;
    end else begin
      stage <= next_stage;
    end
  end

  assign sync_out = stage[STAGES-1];

endmodule : pin_level_sync

// ---- pin_drive_ctrl.sv ----
// Pin driver: decides output value and enable of one pin.
// Assumes an open-drain pad, if fitted, ignores a driven high.
`timescale 1ns/10ps
module pin_drive_ctrl (
  // Control
  input  wire logic                    gpio_role,
  input  wire logic                    dir_out,
  input  wire logic                    out_value,
  input  wire logic                    open_drain,
  // Pad
  output pin_gpio_pkg::pin_drive_s     drive
);
  import pin_gpio_pkg::*;

  // Drive only in GPIO role with direction output
  always_comb begin
    drive.out = out_value;                                   // RQ8
    drive.oe  = gpio_role & dir_out &
                (~open_drain | ~out_value);                  // RQ6 RQ9
  end

endmodule : pin_drive_ctrl

// ---- pin_gpio_top.sv ----
// Top: AXI4-Lite slave and GPIO data path of the two serial pins.
// Assumes pin inputs come from the pad input buffers; serial engine sits
// outside and reads the gated pin levels given here.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
// Contract
// RQ1: Input register shows true pin levels always
// RQ2: Input reading comes through a synchroniser
// RQ3: Bit1 data, bit0 clock; writes ignored
// RQ4: Output value held, readable any time
// RQ5: Role or direction writes keep output value
// RQ6: Drive only in GPIO role and output
// RQ7: Output value reads return register, not pins
// RQ8: Bit1 data, bit0 clock; 0 low 1 high
// RQ9: Open-drain pad cannot be driven high
// RQ10: Set alias sets bits written one
// RQ11: Clear alias clears bits written one
// RQ12: Alias reads are indeterminate
// RQ13: Bits 31 to 2 read zero
// RQ14: Role bit 0 serial, 1 GPIO
// RQ15: Direction bit 0 input, 1 output
// RQ16: Engine sees ones in GPIO role
// RQ17: Software resets engine before role change
// RQ18: Output resets to 0; two-stage sync
module pin_gpio_top #(
  parameter logic [1:0] OPEN_DRAIN = 2'h3
) (
  // Clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // AXI4-Lite write address
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [pin_gpio_pkg::ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  // AXI4-Lite write response
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  output logic [1:0]                        s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  input  wire logic [pin_gpio_pkg::ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  // Serial data pin
  input  wire logic                         serial_data_pin_in,
  output logic                              serial_data_pin_out,
  output logic                              serial_data_pin_oe,
  // Serial clock pin
  input  wire logic                         serial_clock_pin_in,
  output logic                              serial_clock_pin_out,
  output logic                              serial_clock_pin_oe,
  // Levels seen by the serial engine
  output logic                              engine_data_in,
  output logic                              engine_clock_in
);
  import pin_gpio_pkg::*;

  typedef enum logic [1:0] {WR_IDLE, WR_RESP} wr_state_e;

  // Write channel state
  wr_state_e         wr_state;
  wr_state_e         next_wr_state;
  logic              aw_held;
  logic              next_aw_held;
  logic              w_held;
  logic              next_w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0]       w_data;
  logic [31:0]       next_w_data;
  logic [3:0]        w_strb;
  logic [3:0]        next_w_strb;
  logic [1:0]        bresp;
  logic [1:0]        next_bresp;

  // Read channel state
  logic              rvalid;
  logic              next_rvalid;
  logic [31:0]       rdata;
  logic [31:0]       next_rdata;
  logic [1:0]        rresp;
  logic [1:0]        next_rresp;

  // Registers
  logic [1:0]        pin_output_value;
  logic [1:0]        next_pin_output_value;
  logic              pin_role_select;
  logic              next_pin_role_select;
  logic [1:0]        pin_direction_bits;
  logic [1:0]        next_pin_direction_bits;

  // Pin side
  logic [1:0]        pin_input_level;
  pin_drive_s        data_drive;
  pin_drive_s        clock_drive;
  pin_drive_s        data_drive_q;
  pin_drive_s        clock_drive_q;
  logic [1:0]        engine_in;
  logic [1:0]        next_engine_in;

  pin_level_sync #(
    .WIDTH   (2),
    .STAGES  (SYNC_STAGES)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({serial_data_pin_in, serial_clock_pin_in}),     // RQ1 RQ2 RQ18
    .sync_out (pin_input_level)
  );

  pin_drive_ctrl u_data_drive (
    .gpio_role  (pin_role_select == ROLE_GPIO),                 // RQ14
    .dir_out    (pin_direction_bits[BIT_DATA_PIN]),             // RQ15
    .out_value  (pin_output_value[BIT_DATA_PIN]),               // RQ8
    .open_drain (OPEN_DRAIN[BIT_DATA_PIN]),
    .drive      (data_drive)
  );

  pin_drive_ctrl u_clock_drive (
    .gpio_role  (pin_role_select == ROLE_GPIO),                 // RQ14
    .dir_out    (pin_direction_bits[BIT_CLOCK_PIN]),            // RQ15
    .out_value  (pin_output_value[BIT_CLOCK_PIN]),              // RQ8
    .open_drain (OPEN_DRAIN[BIT_CLOCK_PIN]),
    .drive      (clock_drive)
  );

  // Write path: address and data taken in either order
  always_comb begin
    logic do_write;
    logic mapped;
    do_write                = 1'b0;
    mapped                  = 1'b0;
    next_wr_state           = wr_state;
    next_aw_held            = aw_held;
    next_w_held             = w_held;
    next_aw_addr            = aw_addr;
    next_w_data             = w_data;
    next_w_strb             = w_strb;
    next_bresp              = bresp;
    next_pin_output_value   = pin_output_value;
    next_pin_role_select    = pin_role_select;
    next_pin_direction_bits = pin_direction_bits;
    unique case (wr_state)
      WR_IDLE: begin
        if (s_axi_awvalid && !aw_held) begin
          next_aw_held = 1'b1;
          next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
          next_w_held = 1'b1;
          next_w_data = s_axi_wdata;
          next_w_strb = s_axi_wstrb;
        end
        do_write = next_aw_held && next_w_held;
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          next_wr_state = WR_IDLE;
        end
      end
    endcase
    if (do_write) begin
      next_aw_held  = 1'b0;
      next_w_held   = 1'b0;
      next_wr_state = WR_RESP;
      mapped        = 1'b1;
      // Only byte lane 0 holds live bits; upper bits dropped
      if (next_w_strb[0]) begin                                 // RQ13
        unique case ({next_aw_addr[ADDR_W-1:2], 2'h0})
          OFS_INPUT_LEVEL: ;                                    // RQ3
          OFS_OUT_VALUE:
            next_pin_output_value = next_w_data[1:0];           // RQ4
          OFS_OUT_SET:
            next_pin_output_value =
              pin_output_value | next_w_data[1:0];              // RQ10
          OFS_OUT_CLEAR:
            next_pin_output_value =
              pin_output_value & ~next_w_data[1:0];             // RQ11
          // Role and direction leave the output value alone
          OFS_ROLE:
            next_pin_role_select = next_w_data[BIT_ROLE];       // RQ5
          OFS_DIRECTION:
            next_pin_direction_bits = next_w_data[1:0];         // RQ5
          default: mapped = 1'b0;
        endcase
      end else if (next_aw_addr > OFS_DIRECTION + 6'h3) begin
        mapped = 1'b0;
      end
      next_bresp = mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Read path; alias reads return zero, which software must not rely on
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end else if (!rvalid && s_axi_arvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = '0;                                         // RQ13
      unique case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
        OFS_INPUT_LEVEL: next_rdata[1:0] = pin_input_level;     // RQ1 RQ3
        OFS_OUT_VALUE:   next_rdata[1:0] = pin_output_value;    // RQ7
        OFS_OUT_SET:     ;                                      // RQ12
        OFS_OUT_CLEAR:   ;                                      // RQ12
        OFS_ROLE:        next_rdata[BIT_ROLE] = pin_role_select;
        OFS_DIRECTION:   next_rdata[1:0] = pin_direction_bits;
        default:         next_rresp = RESP_SLVERR;
      endcase
    end
  end

  // Engine sees constant ones while pins serve as GPIO
  always_comb begin
    next_engine_in = (pin_role_select == ROLE_GPIO) ?
                     2'h3 : pin_input_level;                    // RQ16
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state           <= WR_IDLE;
      aw_held            <= 1'b0;
      w_held             <= 1'b0;
      aw_addr            <= '0;
      w_data             <= '0;
      w_strb             <= '0;
      bresp              <= RESP_OKAY;
      rvalid             <= 1'b0;
      rdata              <= '0;
      rresp              <= RESP_OKAY;
      pin_output_value   <= OUT_VALUE_RST;                      // RQ18
      pin_role_select    <= ROLE_RST;
      pin_direction_bits <= DIRECTION_RST;
      data_drive_q       <= '0;
      clock_drive_q      <= '0;
      engine_in          <= 2'h3;
    end else begin
      wr_state           <= next_wr_state;
      aw_held            <= next_aw_held;
      w_held             <= next_w_held;
      aw_addr            <= next_aw_addr;
      w_data             <= next_w_data;
      w_strb             <= next_w_strb;
      bresp              <= next_bresp;
      rvalid             <= next_rvalid;
      rdata              <= next_rdata;
      rresp              <= next_rresp;
      pin_output_value   <= next_pin_output_value;
      pin_role_select    <= next_pin_role_select;
      pin_direction_bits <= next_pin_direction_bits;
      data_drive_q       <= data_drive;
      clock_drive_q      <= clock_drive;
      engine_in          <= next_engine_in;
    end
  end

  assign s_axi_awready        = (wr_state == WR_IDLE) && !aw_held;
  assign s_axi_wready         = (wr_state == WR_IDLE) && !w_held;
  assign s_axi_bvalid         = (wr_state == WR_RESP);
  assign s_axi_bresp          = bresp;
  assign s_axi_arready        = !rvalid;
  assign s_axi_rvalid         = rvalid;
  assign s_axi_rdata          = rdata;
  assign s_axi_rresp          = rresp;
  assign serial_data_pin_out  = data_drive_q.out;
  assign serial_data_pin_oe   = data_drive_q.oe;
  assign serial_clock_pin_out = clock_drive_q.out;
  assign serial_clock_pin_oe  = clock_drive_q.oe;
  assign engine_data_in       = engine_in[BIT_DATA_PIN];
  assign engine_clock_in      = engine_in[BIT_CLOCK_PIN];

endmodule : pin_gpio_top

// ---- pin_board_model.sv ----
// Board model: pull-ups on both serial pins plus a remote device.
// Assumes the remote side only ever pulls a line low.
`timescale 1ns/10ps
module pin_board_model (
  // Pad drive from the block
  input  wire logic data_out,
  input  wire logic data_oe,
  input  wire logic clock_out,
  input  wire logic clock_oe,
  // Remote device pulls
  input  wire logic ext_data_low,
  input  wire logic ext_clock_low,
  // Resolved wire levels
  output logic      data_level,
  output logic      clock_level
);
  // Wired-AND: released lines float up, any low driver wins
  assign data_level  = !ext_data_low & (!data_oe | data_out);
  assign clock_level = !ext_clock_low & (!clock_oe | clock_out);
endmodule : pin_board_model

// ---- pin_gpio_sva.sv ----
// Checker: bus timing and pin behaviour of the pin data path top.
// Assumes it is bound to pin_gpio_top and sees only its ports.
`timescale 1ns/10ps
module pin_gpio_sva
  import pin_gpio_pkg::*;
#(
  parameter logic [1:0] OPEN_DRAIN = 2'h3
) (
  // Clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // Bus
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [ADDR_W-1:0]   s_axi_araddr,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [31:0]         s_axi_rdata,
  // Pins and engine
  input wire logic                serial_data_pin_in,
  input wire logic                serial_data_pin_out,
  input wire logic                serial_data_pin_oe,
  input wire logic                serial_clock_pin_in,
  input wire logic                serial_clock_pin_oe,
  input wire logic                engine_data_in,
  input wire logic                engine_clock_in
);
  logic [1:0] pins_q;
  logic [1:0] stable_cnt;
  logic [1:0] next_stable_cnt;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pins must sit still long enough to cross the synchroniser
  always_comb begin
    if ({serial_data_pin_in, serial_clock_pin_in} != pins_q)
      next_stable_cnt = 2'h0;
    else if (stable_cnt == 2'h3)
      next_stable_cnt = 2'h3;
    else
      next_stable_cnt = stable_cnt + 2'h1;
  end
  always_ff @(posedge aclk) begin
    pins_q     <= {serial_data_pin_in, serial_clock_pin_in};
    stable_cnt <= aresetn ? next_stable_cnt : 2'h0;
  end
  property p_in_level;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_INPUT_LEVEL &&
    stable_cnt == 2'h3 |=> s_axi_rdata[1:0] == $past(pins_q);
  endproperty
  a_in_level: assert property (p_in_level)
    else $error("input level read differs from settled pins");
  property p_rd_zero;
    s_axi_rvalid |-> s_axi_rdata[31:2] == 30'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("read data upper bits not zero");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read data late");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write response late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read address taken while data pending");
  property p_od_data;
    OPEN_DRAIN[BIT_DATA_PIN] && serial_data_pin_oe |-> !serial_data_pin_out;
  endproperty
  a_od_data: assert property (p_od_data)
    else $error("open-drain data pin driven high");
  property p_oe_cause;
    $rose(serial_data_pin_oe) || $rose(serial_clock_pin_oe)
      |-> $past(s_axi_bvalid);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("pin drive enabled without a register write");
  property p_rst_quiet;
    $rose(aresetn) |-> (!serial_data_pin_oe && !serial_clock_pin_oe &&
      engine_data_in && engine_clock_in) ##1
      (engine_data_in && engine_clock_in);
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("pins or engine levels wrong after reset");
endmodule : pin_gpio_sva

bind pin_gpio_top pin_gpio_sva #(.OPEN_DRAIN(OPEN_DRAIN)) u_sva (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .serial_data_pin_in(serial_data_pin_in),
  .serial_data_pin_out(serial_data_pin_out),
  .serial_data_pin_oe(serial_data_pin_oe),
  .serial_clock_pin_in(serial_clock_pin_in),
  .serial_clock_pin_oe(serial_clock_pin_oe),
  .engine_data_in(engine_data_in), .engine_clock_in(engine_clock_in));

// ---- tb.sv ----
// Testbench: drives the pin data path over AXI4-Lite against a board model.
// Assumes data pad open drain, clock pad push-pull (OPEN_DRAIN 2'h2).
`timescale 1ns/10ps
module tb;
  import pin_gpio_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        d_in, d_out, d_oe, c_in, c_out, c_oe, eng_d, eng_c;
  logic        ext_d_low, ext_c_low;
  int          err_total, cmp_count;
  pin_gpio_top #(.OPEN_DRAIN(2'h2)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .serial_data_pin_in(d_in),
    .serial_data_pin_out(d_out), .serial_data_pin_oe(d_oe),
    .serial_clock_pin_in(c_in), .serial_clock_pin_out(c_out),
    .serial_clock_pin_oe(c_oe), .engine_data_in(eng_d),
    .engine_clock_in(eng_c));
  pin_board_model u_board (
    .data_out(d_out), .data_oe(d_oe), .clock_out(c_out), .clock_oe(c_oe),
    .ext_data_low(ext_d_low), .ext_clock_low(ext_c_low),
    .data_level(d_in), .clock_level(c_in));
  task automatic test_done;
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] exp_resp);
    int n;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 40) begin
      err_total++;
      test_done();
    end
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, exp_resp});
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] exp,
                    input logic [1:0] exp_resp, input bit cmp_data);
    int n;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 40) begin
      err_total++;
      test_done();
    end
    rv = rdata;
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, exp_resp});
    if (cmp_data) chk(rv, exp);
  endtask : rd
  // Covers synchroniser plus pad register delay
  task automatic settle;
    repeat (4) @(posedge aclk);
  endtask : settle
  task automatic s_reset_state;
    rd(OFS_OUT_VALUE, 32'h0, RESP_OKAY, 1);
    settle();
    rd(OFS_INPUT_LEVEL, 32'h3, RESP_OKAY, 1);
    chk({30'h0, d_oe, c_oe}, 32'h0);
  endtask : s_reset_state
  task automatic s_drive;
    wr(OFS_ROLE, 32'h1, RESP_OKAY);
    wr(OFS_DIRECTION, 32'h3, RESP_OKAY);
    wr(OFS_OUT_VALUE, 32'h1, RESP_OKAY);
    settle();
    chk({28'h0, d_oe, d_out, c_oe, c_out}, 32'hB);
    rd(OFS_INPUT_LEVEL, 32'h1, RESP_OKAY, 1);
    wr(OFS_OUT_VALUE, 32'h2, RESP_OKAY);
    settle();
    chk({29'h0, d_oe, c_oe, c_out}, 32'h2);
    rd(OFS_INPUT_LEVEL, 32'h2, RESP_OKAY, 1);
  endtask : s_drive
  task automatic s_alias;
    wr(OFS_OUT_SET, 32'hFFFF_FFFD, RESP_OKAY);
    rd(OFS_OUT_VALUE, 32'h3, RESP_OKAY, 1);
    wr(OFS_OUT_CLEAR, 32'hFFFF_FFFE, RESP_OKAY);
    rd(OFS_OUT_VALUE, 32'h1, RESP_OKAY, 1);
    wr(OFS_OUT_SET, 32'h0, RESP_OKAY);
    wr(OFS_OUT_CLEAR, 32'hFFFF_FFFC, RESP_OKAY);
    rd(OFS_OUT_VALUE, 32'h1, RESP_OKAY, 1);
    wr(OFS_OUT_VALUE, 32'hFFFF_FFFE, RESP_OKAY);
    rd(OFS_OUT_VALUE, 32'h2, RESP_OKAY, 1);
    rd(OFS_OUT_SET, 32'h0, RESP_OKAY, 0);
  endtask : s_alias
  task automatic s_role_dir;
    wr(OFS_DIRECTION, 32'h1, RESP_OKAY);
    settle();
    chk({29'h0, d_oe, c_oe, c_out}, 32'h2);
    wr(OFS_ROLE, 32'h0, RESP_OKAY);
    settle();
    chk({30'h0, d_oe, c_oe}, 32'h0);
    rd(OFS_OUT_VALUE, 32'h2, RESP_OKAY, 1);
    wr(OFS_DIRECTION, 32'h0, RESP_OKAY);
    rd(OFS_OUT_VALUE, 32'h2, RESP_OKAY, 1);
  endtask : s_role_dir
  task automatic s_engine;
    @(posedge aclk);
    ext_d_low <= 1'b1;
    settle();
    chk({30'h0, eng_d, eng_c}, 32'h1);
    rd(OFS_INPUT_LEVEL, 32'h1, RESP_OKAY, 1);
    rd(OFS_OUT_VALUE, 32'h2, RESP_OKAY, 1);
    wr(OFS_ROLE, 32'h1, RESP_OKAY);
    settle();
    chk({30'h0, eng_d, eng_c}, 32'h3);
    rd(OFS_INPUT_LEVEL, 32'h1, RESP_OKAY, 1);
    @(posedge aclk);
    ext_d_low <= 1'b0;
  endtask : s_engine
  task automatic s_read_only;
    wr(OFS_INPUT_LEVEL, 32'h0, RESP_OKAY);
    settle();
    rd(OFS_INPUT_LEVEL, 32'h3, RESP_OKAY, 1);
    wr(6'h18, 32'h3, RESP_SLVERR);
    rd(6'h18, 32'h0, RESP_SLVERR, 0);
    wstrb <= 4'hE;
    wr(OFS_OUT_VALUE, 32'h1, RESP_OKAY);
    wstrb <= 4'hF;
    rd(OFS_OUT_VALUE, 32'h2, RESP_OKAY, 1);
  endtask : s_read_only
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    aresetn   = 1'b0;
    awvalid   = 1'b0;
    wvalid    = 1'b0;
    bready    = 1'b0;
    arvalid   = 1'b0;
    rready    = 1'b0;
    awaddr    = 6'h0;
    araddr    = 6'h0;
    wdata     = 32'h0;
    wstrb     = 4'hF;
    ext_d_low = 1'b0;
    ext_c_low = 1'b0;
    err_total = 0;
    cmp_count = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    s_reset_state();
    s_drive();
    s_alias();
    s_role_dir();
    s_engine();
    s_read_only();
    test_done();
  end
endmodule : tb
